// ---- logic/vcsp_map.vh ----
// Constants for the voice codec serial port
`ifndef VCSP_MAP_VH
`define VCSP_MAP_VH
`define VCSP_COMP_BITS     5'h08
`define VCSP_LIN_BITS      5'h10
`define VCSP_LIN_DATA_MSB  4'hf
`define VCSP_LIN_DATA_LSB  4'h3
`define VCSP_STANDBY_FRMS  3'h5
`define VCSP_MU_BIAS       14'h0084
`define VCSP_FIFO_DEPTH    16
`endif

// ---- logic/vcsp_fifo.v ----
// Parameterised synchronous FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module vcsp_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   output reg              outValid,
   input  wire             outReady,
   output reg  [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wrPtr_q;
   reg [AW:0]      rdPtr_q;
   wire [AW:0]     count   = wrPtr_q - rdPtr_q;
   wire            empty   = (count == {(AW+1){1'b0}});
   wire            loadOut = !empty && (!outValid || outReady);
   // The output register holds a word too, so it counts toward the depth
   wire [AW:0]     held    = count + {{AW{1'b0}}, outValid};
   assign inReady = (held != DEPTH[AW:0]);
   always @(posedge ref_clk) begin
      if (inValid && inReady)
         mem[wrPtr_q[AW-1:0]] <= inData;
   end
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wrPtr_q  <= {(AW+1){1'b0}};
         rdPtr_q  <= {(AW+1){1'b0}};
         outValid <= 1'b0;
         outData  <= {WIDTH{1'b0}};
      end else begin
         if (inValid && inReady)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (loadOut) begin
            outData  <= mem[rdPtr_q[AW-1:0]];
            rdPtr_q  <= rdPtr_q + 1'b1;
            outValid <= 1'b1;
         end else if (outReady)
            outValid <= 1'b0;
      end
   end
endmodule // vcsp_fifo
`default_nettype wire

// ---- logic/vcsp_serial_port.v ----
// Serial data port of a voice-band codec: framing, companding, standby
`timescale 1ns/1ps
`default_nettype none
`include "vcsp_map.vh"
module vcsp_serial_port #(
   parameter A_LAW = 0
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        masterClk,
   input  wire        rxBitClockRateSelect,
   input  wire        txBitClockIn,
   input  wire        txFrameSync,
   input  wire        rxFrameSync,
   input  wire        codingSelect,
   input  wire        dataIn,
   output reg         dataOut,
   output wire        txSlotStrobeN_o,
   output wire        txSlotStrobeN_oe,
   input  wire        txSampleValid,
   output wire        txSampleReady,
   input  wire [12:0] txSample,
   input  wire [2:0]  txGain,
   output reg         rxSampleValid,
   output reg  [12:0] rxSample,
   output reg  [2:0]  rxGain,
   output reg         fixedRate,
   output reg         txStandby,
   output reg         rxStandby
);
   // -----------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   reg [1:0] clkHist_q;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {masterClk, rxBitClockRateSelect, txBitClockIn,
                     txFrameSync, rxFrameSync, codingSelect, dataIn};
         sync2_q <= sync1_q;
      end
   end
   wire mClkS  = sync2_q[6];
   wire rSelS  = sync2_q[5];
   wire txClkS = sync2_q[4];
   wire fsxS   = sync2_q[3];
   wire fsrS   = sync2_q[2];
   wire linS   = sync2_q[1];
   wire dinS   = sync2_q[0];
   wire companded = linS;

   // -----------------------------------------------------------
   // Rate mode and edge detection
   // -----------------------------------------------------------
   // A free-running receive clock also goes high, so fixed mode needs
   // the select pin to stay high across three master-clock rising edges.
   reg  [3:0] highCnt_q;
   reg        mClkD_q;
   reg        txClkD_q;
   reg        rxClkD_q;
   wire       mRise = mClkS && !mClkD_q;
   wire       mFall = !mClkS && mClkD_q;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         highCnt_q <= 4'h0;
         fixedRate <= 1'b0;
         mClkD_q   <= 1'b0;
         txClkD_q  <= 1'b0;
         rxClkD_q  <= 1'b0;
      end else begin
         mClkD_q  <= mClkS;
         txClkD_q <= txClkS;
         rxClkD_q <= rSelS;
         if (!rSelS) begin
            highCnt_q <= 4'h0;
            fixedRate <= 1'b0;
         end else if (mRise) begin
            if (highCnt_q == 4'h2)
               fixedRate <= 1'b1;
            else
               highCnt_q <= highCnt_q + 4'h1;
         end
      end
   end
   wire txRise = fixedRate ? mRise : (txClkS && !txClkD_q);
   wire rxFall = fixedRate ? mFall : (!rSelS && rxClkD_q);

   // -----------------------------------------------------------
   // Companding helpers
   // -----------------------------------------------------------
   function [7:0] compress;
      input [12:0] lin;
      input        aLaw;
      reg   [13:0] mag;
      reg   [2:0]  seg;
      reg   [3:0]  man;
      reg          neg;
      integer      i;
      begin
         neg = lin[12];
         mag = neg ? (14'h0000 - {lin[12], lin}) : {1'b0, lin};
         if (!aLaw)
            mag = mag + (`VCSP_MU_BIAS >> 2);
         if (mag > 14'h1fff)
            mag = 14'h1fff;
         seg = 3'h0;
         // The biased law puts each segment one bit higher than the other
         for (i = 1; i < 8; i = i + 1)
            if (aLaw ? mag[i+4] : mag[i+5])
               seg = i[2:0];
         if (!aLaw)
            man = mag[seg+1+:4];
         else
            man = (seg == 3'h0) ? mag[4:1] : mag[seg+:4];
         if (!aLaw)
            compress = ~{neg, seg, man};
         else
            compress = {!neg, seg, man} ^ 8'h55;
      end
   endfunction

   function [12:0] expand;
      input [7:0] code;
      input       aLaw;
      reg   [7:0] c;
      reg   [13:0] mag;
      reg          pos;
      begin
         c = aLaw ? (code ^ 8'h55) : ~code;
         mag = ({10'h000, c[3:0]} << 1) | 14'h0001;
         if (!aLaw)
            mag = ((mag | 14'h0020) << c[6:4]) - (`VCSP_MU_BIAS >> 2);
         else if (c[6:4] != 3'h0)
            mag = (mag | 14'h0020) << (c[6:4] - 3'h1);
         // Sign sense differs between the two laws
         pos = aLaw ? c[7] : !c[7];
         expand = pos ? mag[12:0] : (13'h0000 - mag[12:0]);
      end
   endfunction

   // -----------------------------------------------------------
   // Transmit path
   // -----------------------------------------------------------
   wire        fifoValid;
   wire        fifoTake;
   wire [15:0] fifoData;
   vcsp_fifo #(
      .WIDTH (16),
      .DEPTH (`VCSP_FIFO_DEPTH),
      .AW    (4)
   ) uTxFifo (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .inValid  (txSampleValid),
      .inReady  (txSampleReady),
      .inData   ({txSample, txGain}),
      .outValid (fifoValid),
      .outReady (fifoTake),
      .outData  (fifoData)
   );

   reg [15:0] txShift_q;
   reg [4:0]  txLeft_q;
   reg        fsxD_q;
   reg        txArm_q;
   reg [2:0]  fsxLow_q;
   reg        fsxSeen_q;
   wire [4:0] txBits = companded ? `VCSP_COMP_BITS : `VCSP_LIN_BITS;
   assign fifoTake = txRise && txArm_q && fsxS;
   wire [15:0] txWord = !fifoValid ? 16'h0000 :
                        companded ? {compress(fifoData[15:3], A_LAW != 0), 8'h00} :
                        fifoData;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txShift_q <= 16'h0000;
         txLeft_q  <= 5'h00;
         fsxD_q    <= 1'b0;
         txArm_q   <= 1'b0;
         dataOut   <= 1'b0;
         fsxLow_q  <= 3'h0;
         fsxSeen_q <= 1'b0;
         txStandby <= 1'b1;
      end else begin
         fsxD_q <= fsxS;
         // The waking sync edge also opens a slot, so the first word is not lost
         if (fsxS && !fsxD_q)
            txArm_q <= 1'b1;
         if (fsxS) begin
            fsxSeen_q <= 1'b1;
            fsxLow_q  <= 3'h0;
            txStandby <= 1'b0;
         end
         if (txRise) begin
            if (fifoTake) begin
               // MSB leaves on the first rising edge of the slot
               dataOut   <= txWord[15];
               txShift_q <= {txWord[14:0], 1'b0};
               txLeft_q  <= txBits - 5'h01;
               txArm_q   <= 1'b0;
            end else if (txLeft_q != 5'h00) begin
               dataOut   <= txShift_q[15];
               txShift_q <= {txShift_q[14:0], 1'b0};
               txLeft_q  <= txLeft_q - 5'h01;
            end else
               dataOut <= 1'b0;
         end
         // In fixed-rate mode only, one frame counted per master-clock period while sync stays low
         if (!fsxS && mRise && fixedRate) begin
            if (fsxLow_q == `VCSP_STANDBY_FRMS - 3'h1)
               txStandby <= 1'b1;
            else
               fsxLow_q <= fsxLow_q + 3'h1;
         end
      end
   end
   // Open-drain strobe pulls low while a fixed-rate word is in flight
   assign txSlotStrobeN_o  = 1'b0;
   assign txSlotStrobeN_oe = fixedRate && (txLeft_q != 5'h00);

   // -----------------------------------------------------------
   // Receive path
   // -----------------------------------------------------------
   reg [15:0] rxShift_q;
   reg [4:0]  rxCnt_q;
   reg        rxBusy_q;
   reg        fsrD_q;
   reg [2:0]  fsrLow_q;
   wire [4:0] rxBits = companded ? `VCSP_COMP_BITS : `VCSP_LIN_BITS;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxShift_q     <= 16'h0000;
         rxCnt_q       <= 5'h00;
         rxBusy_q      <= 1'b0;
         fsrD_q        <= 1'b0;
         fsrLow_q      <= 3'h0;
         rxStandby     <= 1'b1;
         rxSampleValid <= 1'b0;
         rxSample      <= 13'h0000;
         rxGain        <= 3'h0;
      end else begin
         fsrD_q        <= fsrS;
         rxSampleValid <= 1'b0;
         if (fsrS) begin
            fsrLow_q  <= 3'h0;
            rxStandby <= 1'b0;
            if (!fsrD_q) begin
               rxBusy_q <= 1'b1;
               rxCnt_q  <= 5'h00;
            end
         end else if (mRise && fixedRate) begin
            if (fsrLow_q == `VCSP_STANDBY_FRMS - 3'h1)
               rxStandby <= 1'b1;
            else
               fsrLow_q <= fsrLow_q + 3'h1;
         end
         if (rxFall && rxBusy_q && !rxStandby) begin
            rxShift_q <= {rxShift_q[14:0], dinS};
            rxCnt_q   <= rxCnt_q + 5'h01;
            if (rxCnt_q == rxBits - 5'h01) begin
               rxBusy_q      <= 1'b0;
               rxSampleValid <= 1'b1;
               if (companded) begin
                  rxSample <= expand({rxShift_q[6:0], dinS}, A_LAW != 0);
                  rxGain   <= 3'h0;
               end else begin
                  rxSample <= rxShift_q[14:2];
                  rxGain   <= {rxShift_q[1:0], dinS};
               end
            end
         end
      end
   end
endmodule // vcsp_serial_port
`default_nettype wire

// ---- test/vcsp_checker_properties.sv ----
// Concurrent checks on the serial port's pins
`timescale 1ns/1ps
`default_nettype none
module vcsp_checker (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       txFrameSync,
   input wire logic       rxFrameSync,
   input wire logic       rxBitClockRateSelect,
   input wire logic       codingSelect,
   input wire logic       dataOut,
   input wire logic       txSlotStrobeN_o,
   input wire logic       txSlotStrobeN_oe,
   input wire logic       rxSampleValid,
   input wire logic [2:0] rxGain,
   input wire logic       fixedRate,
   input wire logic       txStandby,
   input wire logic       rxStandby
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_strobe_low_drive: assert property (txSlotStrobeN_o == 1'b0)
      else $error("strobe drive value not low");
   a_strobe_fixed_only: assert property (txSlotStrobeN_oe |-> fixedRate && !txStandby)
      else $error("strobe pulled outside a fixed-rate slot");
   a_valid_one_cycle: assert property (rxSampleValid |=> !rxSampleValid)
      else $error("receive valid longer than one cycle");
   a_comp_gain_zero: assert property (rxSampleValid && codingSelect |-> rxGain == 3'h0)
      else $error("companded word carried gain bits");
   a_idle_dout_low: assert property (txStandby |-> !dataOut)
      else $error("serial output active in standby");
   // Sync is synchronised, so allow a few cycles before standby drops
   a_tx_sync_wake: assert property (txFrameSync [*8] |-> !txStandby)
      else $error("transmit standby kept under high sync");
   a_rx_sync_wake: assert property (rxFrameSync [*8] |-> !rxStandby)
      else $error("receive standby kept under high sync");
   a_fixed_from_select: assert property ($rose(fixedRate) |-> $past(rxBitClockRateSelect, 5))
      else $error("fixed rate entered with select low");
   c_rx_companded: cover property (rxSampleValid && codingSelect);
   c_rx_linear: cover property (rxSampleValid && !codingSelect);
   c_fixed_entry: cover property ($rose(fixedRate));
endmodule // vcsp_checker
bind vcsp_serial_port vcsp_checker vcsp_checker_i (
   .ref_clk, .rst, .txFrameSync, .rxFrameSync, .rxBitClockRateSelect, .codingSelect,
   .dataOut, .txSlotStrobeN_o, .txSlotStrobeN_oe, .rxSampleValid, .rxGain, .fixedRate,
   .txStandby, .rxStandby);
`default_nettype wire

// ---- test/vcsp_dsp_model.sv ----
// Far-side processor model: bit clock, frame sync and serial data
`timescale 1ns/1ps
`default_nettype none
module vcsp_dsp_model (
   output var logic  bitClk,
   output var logic  sync,
   output var logic  dataToCodec,
   input  wire logic dataFromCodec
);
   initial begin
      bitClk = 1'b0;
      sync = 1'b0;
      dataToCodec = 1'b1;
   end
   // Clock stands still between slots; codec output is read late in each bit
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] got);
      got = 16'h0000;
      sync = 1'b1;
      #150;
      for (int i = n - 1; i >= 0; i--) begin
         bitClk = 1'b1;
         dataToCodec = w[i];
         #100;
         bitClk = 1'b0;
         #90;
         got[i] = dataFromCodec;
         #10;
      end
      sync = 1'b0;
      dataToCodec = ~dataToCodec;
      #300;
   endtask
endmodule // vcsp_dsp_model
`default_nettype wire

// ---- test/vcsp_serial_port_tb_top.sv ----
// Testbench for the voice codec serial port
`timescale 1ns/1ps
`default_nettype none
module vcsp_serial_port_tb_top;
   logic        refClk = 1'b0;
   logic        rst = 1'b1;
   logic        masterClk = 1'b0;
   logic        fixedMode = 1'b0;
   logic        codingSelect = 1'b0;
   logic        txSampleValid = 1'b0;
   logic [12:0] txSample = 13'h0000;
   logic [2:0]  txGain = 3'h0;
   logic [15:0] got;
   int          bad_count = 0;
   int          samples_checked = 0;
   wire         bitClk, sync, dataIn, dataOut, strobeO, strobeOe, txSampleReady;
   wire         rxSampleValid, fixedRate, txStandby, rxStandby;
   wire [12:0]  rxSample;
   wire [2:0]   rxGain;
   wire         selPin = fixedMode ? 1'b1 : bitClk;
   // Open-drain strobe shares the tx clock pin; pulled up when undriven in fixed mode
   wire         txPin = strobeOe ? strobeO : (fixedMode ? 1'b1 : bitClk);
   vcsp_serial_port #(.A_LAW(0)) vcsp_serial_port_i (
      .ref_clk(refClk), .rst(rst), .masterClk(masterClk), .rxBitClockRateSelect(selPin),
      .txBitClockIn(txPin), .txFrameSync(sync), .rxFrameSync(sync), .codingSelect(codingSelect),
      .dataIn(dataIn), .dataOut(dataOut), .txSlotStrobeN_o(strobeO), .txSlotStrobeN_oe(strobeOe),
      .txSampleValid(txSampleValid), .txSampleReady(txSampleReady), .txSample(txSample),
      .txGain(txGain), .rxSampleValid(rxSampleValid), .rxSample(rxSample), .rxGain(rxGain),
      .fixedRate(fixedRate), .txStandby(txStandby), .rxStandby(rxStandby));
   vcsp_dsp_model vcsp_dsp_model_i (
      .bitClk(bitClk), .sync(sync), .dataToCodec(dataIn), .dataFromCodec(dataOut));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("compares=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic push(input logic [12:0] s, input logic [2:0] g);
      @(posedge refClk);
      txSampleValid <= 1'b1;
      txSample <= s;
      txGain <= g;
      do @(negedge refClk); while (txSampleReady !== 1'b1);
      @(posedge refClk);
      txSampleValid <= 1'b0;
   endtask
   task automatic reset_values;
      check({12'h000, txStandby, rxStandby, fixedRate, txSampleReady}, 16'h000d);
   endtask
   // Fill the FIFO with no slots running, offer a refused word, then drain it
   task automatic linear_stream;
      for (int i = 0; i < 16; i++) push(13'h1000 | 13'(i * 37), 3'(i));
      @(negedge refClk);
      check({15'h0000, txSampleReady}, 16'h0000);
      @(posedge refClk);
      txSampleValid <= 1'b1;
      txSample <= 13'h0abc;
      repeat (3) @(posedge refClk);
      txSampleValid <= 1'b0;
      for (int i = 0; i < 17; i++) begin
         vcsp_dsp_model_i.frame(16'h8c31 ^ 16'(i * 4369), 16, got);
         check(got, i < 16 ? {13'h1000 | 13'(i * 37), 3'(i)} : 16'h0000);
         check({rxSample, rxGain}, 16'h8c31 ^ 16'(i * 4369));
      end
      check({15'h0000, fixedRate}, 16'h0000);
   endtask
   // Zero sample compresses to the all-ones code, which expands back to zero
   task automatic companded_zero;
      @(posedge refClk);
      codingSelect <= 1'b1;
      push(13'h0000, 3'h5);
      vcsp_dsp_model_i.frame(16'h00ff, 8, got);
      check(got, 16'h00ff);
      check({rxSample, rxGain}, 16'h0000);
   endtask
   task automatic fixed_mode;
      @(posedge refClk);
      fixedMode <= 1'b1;
      repeat (800) @(posedge refClk);
      check({12'h000, fixedRate, txStandby, rxStandby, strobeOe}, 16'h000e);
   endtask
   initial begin
      forever #12.5 refClk = ~refClk;
   end
   initial begin
      forever #200 masterClk = ~masterClk;
   end
   initial begin
      repeat (6) @(posedge refClk);
      rst <= 1'b0;
      repeat (4) @(posedge refClk);
      reset_values();
      linear_stream();
      companded_zero();
      fixed_mode();
      final_report();
   end
   // About 3400 cycles expected; roughly six times that means a hang
   initial begin
      repeat (20000) @(posedge refClk);
      bad_count++;
      final_report();
   end
endmodule // vcsp_serial_port_tb_top
`default_nettype wire
